// File: rtl/mfd_decoder.sv
// instruction field decoder: registers one decoded word per accepted fetch
// assumes fetch words and the updated pc come from logic on core_clk
`default_nettype none
module mfd_decoder
  import mfd_pkg::*;
#(
  parameter bit LOCKED_OPS = 1'b1
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 fetch_valid,
  input  wire logic [WORD_W-1:0]    fetch_word,
  input  wire logic [WORD_W-1:0]    fetch_pc_next,
  output var  logic                 dec_valid,
  output var  logic                 dec_illegal,
  output var  mfd_dec_type          dec_out
);

  ////////////////////////////////////////////////////////////////////////
  // mode decode shared by both fields
  function automatic mfd_mode_type mode_of(input logic [2:0] m);
    mfd_mode_type r;
    r = MODE_REG;
    case (m)
      3'h0: r = MODE_REG;
      3'h1: r = MODE_REG_DEF;
      3'h2: r = MODE_AINC;
      3'h3: r = MODE_AINC_DEF;
      3'h4: r = MODE_ADEC;
      3'h5: r = MODE_ADEC_DEF;
      3'h6: r = MODE_IDX;
      default: r = MODE_IDX_DEF;
    endcase
    return r;
  endfunction : mode_of

  function automatic mfd_spec_type spec_of(input logic [SPEC_W-1:0] f);
    mfd_spec_type s;
    s.mode    = mode_of(f[5:3]);
    s.reg_num = f[2:0];
    return s;
  endfunction : spec_of

  ////////////////////////////////////////////////////////////////////////
  logic        valid_reg, valid_next;
  logic        ill_reg, ill_next;
  mfd_dec_type dec_reg, dec_next;

  logic [2:0]  do_opc;
  logic [6:0]  rd_opc;
  logic [8:0]  so_opc;
  logic [7:0]  br_opc;
  logic [15:0] br_disp;

  assign do_opc  = fetch_word[DO_OP_HI:DO_OP_LO];
  assign rd_opc  = fetch_word[RD_OP_HI:RD_OP_LO];
  assign so_opc  = fetch_word[SO_OP_HI:SO_OP_LO];
  assign br_opc  = fetch_word[BR_OP_HI:BR_OP_LO];
  // offset counts words, pc counts bytes; range stays -128..+127 words
  assign br_disp = {{7{fetch_word[7]}}, fetch_word[7:0], 1'b0};

  always_comb begin
    dec_next            = dec_reg;
    valid_next          = 1'b0;
    ill_next            = ill_reg;
    if (fetch_valid) begin
      valid_next          = 1'b1;
      ill_next            = 1'b0;
      dec_next            = '0;
      dec_next.cls        = CLS_NONE;
      dec_next.op         = OP_NONE;
      dec_next.br_cond    = BR_NONE;
      // fields decoded apart, whatever the other field holds
      dec_next.src        = spec_of(fetch_word[11:6]);
      dec_next.dst        = spec_of(fetch_word[5:0]);
      if (do_opc != 3'h0 && do_opc != DO_EXT) begin
        dec_next.cls      = CLS_DOUBLE;
        dec_next.byte_op  = (do_opc == DO_ADDSUB[2:0]) ? 1'b0 : fetch_word[15];
        case (do_opc)
          DO_COPY:   dec_next.op = OP_COPY;
          DO_CMP:    dec_next.op = OP_CMP;
          DO_BIT:    dec_next.op = OP_BIT;
          DO_BIC:    dec_next.op = OP_BIC;
          DO_BIS:    dec_next.op = OP_BIS;
          DO_ADDSUB: dec_next.op = fetch_word[15] ? OP_SUB : OP_ADD;
          default:   dec_next.op = OP_NONE;
        endcase
      end else if (do_opc == DO_EXT && !fetch_word[15]) begin
        // register forms: reg in 8-6 (the source for XOR, the loop counter for the loop branch), other operand in 5-0
        dec_next.link_reg   = 3'h0;
        dec_next.src        = spec_of(fetch_word[5:0]);
        dec_next.dst        = '{mode: MODE_REG, reg_num: fetch_word[8:6]};
        dec_next.cls        = CLS_REGDST;
        case (fetch_word[11:9])
          EXT_PRODUCT: dec_next.op = OP_PRODUCT;
          EXT_DIV: dec_next.op = OP_DIV;
          EXT_SHA: dec_next.op = OP_SHIFT_ARITH;
          EXT_SHC: dec_next.op = OP_SHIFT_ARITH_COMB;
          EXT_XOR: begin
            dec_next.op         = OP_XOR;
            dec_next.src        = '{mode: MODE_REG, reg_num: fetch_word[8:6]};
            dec_next.dst        = spec_of(fetch_word[5:0]);
          end
          EXT_DEC_LOOP: begin
            dec_next.cls        = CLS_BRANCH;
            dec_next.br_cond    = BR_DEC_LOOP;
            dec_next.link_reg   = fetch_word[8:6];
            // loop offset is six-bit, backward only
            dec_next.br_target  = fetch_pc_next - {9'h000, fetch_word[5:0], 1'b0};
          end
          default: begin
            dec_next.cls        = CLS_NONE;
            ill_next            = 1'b1;
          end
        endcase
      end else if (rd_opc == CALL_OPC[6:0]) begin
        dec_next.cls        = CLS_CALL;
        dec_next.link_reg   = fetch_word[8:6];
        // link of stack pointer, or link equal to a non-pc destination, is left to software
        dec_next.src        = '0;
        dec_next.src.mode   = MODE_REG;
      end else if (fetch_word[15:3] == RET_OPC[12:0]) begin
        dec_next.cls        = CLS_RETURN;
        dec_next.link_reg   = fetch_word[2:0];
      end else if (br_opc == TRAP_EMU_HI || br_opc == TRAP_SW_HI) begin
        dec_next.cls        = CLS_TRAP;
        dec_next.op         = br_opc[0] ? OP_TRAP : OP_EMU_TRAP;
        dec_next.trap_code  = fetch_word[7:0];
        dec_next.src        = '0;
        dec_next.src.mode   = MODE_REG;
        dec_next.dst        = '0;
        dec_next.dst.mode   = MODE_REG;
      end else if (fetch_word[14:11] == 4'h0 && (fetch_word[15] || fetch_word[10:8] != 3'h0)) begin
        dec_next.cls        = CLS_BRANCH;
        dec_next.br_target  = fetch_pc_next + br_disp;
        case ({fetch_word[15], fetch_word[10:8]})
          4'h1: dec_next.br_cond = BR_ALWAYS;
          4'h2: dec_next.br_cond = BR_NE;
          4'h3: dec_next.br_cond = BR_EQ;
          4'h4: dec_next.br_cond = BR_GE;
          4'h5: dec_next.br_cond = BR_LT;
          4'h6: dec_next.br_cond = BR_GT;
          4'h7: dec_next.br_cond = BR_LE;
          // whole high byte is the condition; bit 7 always stays with the offset
          4'h8: dec_next.br_cond = BR_PL;
          4'h9: dec_next.br_cond = BR_MI;
          4'hA: dec_next.br_cond = BR_HI;
          4'hB: dec_next.br_cond = BR_LOS;
          4'hC: dec_next.br_cond = BR_VC;
          4'hD: dec_next.br_cond = BR_VS;
          4'hE: dec_next.br_cond = BR_CC;
          4'hF: dec_next.br_cond = BR_CS;
          default: dec_next.br_cond = BR_NONE;
        endcase
      end else if (fetch_word == NOP_WORD) begin
        dec_next.cls        = CLS_SINGLE;
        dec_next.op         = OP_NOP;
      end else begin
        dec_next.cls        = CLS_SINGLE;
        dec_next.byte_op    = fetch_word[15];
        case ({1'b0, so_opc[7:0]} | {fetch_word[15] & so_opc[8], 8'h00})
          SO_BYTE_SWAP: dec_next.op = fetch_word[15] ? OP_NONE : OP_BYTE_SWAP;
          SO_CLR:  dec_next.op = OP_CLR;
          SO_COM:  dec_next.op = OP_COM;
          SO_INC:  dec_next.op = OP_INC;
          SO_DEC:  dec_next.op = OP_DEC;
          SO_NEG:  dec_next.op = OP_NEG;
          SO_ADC:  dec_next.op = OP_ADC;
          SO_SBC:  dec_next.op = OP_SBC;
          SO_TST:  dec_next.op = OP_TST;
          SO_ROR:  dec_next.op = OP_ROR;
          SO_ROL:  dec_next.op = OP_ROL;
          SO_ASR:  dec_next.op = OP_ASR;
          SO_ASL:  dec_next.op = OP_ASL;
          SO_SIGN_EXT: dec_next.op = fetch_word[15] ? OP_NONE : OP_SIGN_EXT;
          default: dec_next.op = OP_NONE;
        endcase
        if (LOCKED_OPS && so_opc == SO_MARK_LOW) begin
          dec_next.op       = OP_MARK_LOW;
          dec_next.byte_op  = 1'b0;
        end
        if (LOCKED_OPS && so_opc == SO_LOCKUPD) begin
          dec_next.op       = OP_LOCKUPD;
          dec_next.byte_op  = 1'b0;
          dec_next.src      = '{mode: MODE_REG, reg_num: 3'h0};
        end
        if (dec_next.op == OP_NONE) begin
          dec_next.cls      = CLS_NONE;
          ill_next          = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      valid_reg <= 1'b0;
      ill_reg   <= 1'b0;
      dec_reg   <= '{cls: CLS_NONE, op: OP_NONE, br_cond: BR_NONE,
                     src: '{mode: MODE_REG, reg_num: 3'h0}, dst: '{mode: MODE_REG, reg_num: 3'h0},
                     default: '0};
    end else begin
      valid_reg <= valid_next;
      ill_reg   <= ill_next;
      dec_reg   <= dec_next;
    end
  end

  assign dec_valid   = valid_reg;
  assign dec_illegal = ill_reg;
  assign dec_out     = dec_reg;

endmodule : mfd_decoder
`default_nettype wire

// File: rtl/mfd_pkg.sv
// package for the instruction field decoder: field positions, opcodes, codes
// assumes a single 100 MHz core clock and 16-bit instruction words
`default_nettype none
package mfd_pkg;
  localparam int WORD_W = 16;
  localparam int SO_OP_HI = 14;
  localparam int SO_OP_LO = 6;
  localparam int DO_OP_HI = 14;
  localparam int DO_OP_LO = 12;
  localparam int RD_OP_HI = 15;
  localparam int RD_OP_LO = 9;
  localparam int BR_OP_HI = 15;
  localparam int BR_OP_LO = 8;
  localparam int SPEC_W = 6;
  localparam int ADD_SUB_OPC = 6;
  localparam int CALL_OPC = 4;
  localparam int RET_OPC = 16;
  localparam logic [2:0] DO_COPY = 3'h1;
  localparam logic [2:0] DO_CMP = 3'h2;
  localparam logic [2:0] DO_BIT = 3'h3;
  localparam logic [2:0] DO_BIC = 3'h4;
  localparam logic [2:0] DO_BIS = 3'h5;
  localparam logic [2:0] DO_ADDSUB = 3'h6;
  localparam logic [2:0] DO_EXT = 3'h7;
  localparam logic [2:0] EXT_PRODUCT = 3'h0;
  localparam logic [2:0] EXT_DIV = 3'h1;
  localparam logic [2:0] EXT_SHA = 3'h2;
  localparam logic [2:0] EXT_SHC = 3'h3;
  localparam logic [2:0] EXT_XOR = 3'h4;
  localparam logic [2:0] EXT_DEC_LOOP = 3'h7;
  localparam logic [8:0] SO_BYTE_SWAP = 9'h003;
  localparam logic [8:0] SO_CLR = 9'h028;
  localparam logic [8:0] SO_COM = 9'h029;
  localparam logic [8:0] SO_INC = 9'h02A;
  localparam logic [8:0] SO_DEC = 9'h02B;
  localparam logic [8:0] SO_NEG = 9'h02C;
  localparam logic [8:0] SO_ADC = 9'h02D;
  localparam logic [8:0] SO_SBC = 9'h02E;
  localparam logic [8:0] SO_TST = 9'h02F;
  localparam logic [8:0] SO_ROR = 9'h030;
  localparam logic [8:0] SO_ROL = 9'h031;
  localparam logic [8:0] SO_ASR = 9'h032;
  localparam logic [8:0] SO_ASL = 9'h033;
  localparam logic [8:0] SO_SIGN_EXT = 9'h037;
  localparam logic [8:0] SO_MARK_LOW = 9'h03A;
  localparam logic [8:0] SO_LOCKUPD = 9'h03B;
  localparam logic [15:0] NOP_WORD = 16'h00A0;
  localparam logic [7:0] TRAP_EMU_HI = 8'h88;
  localparam logic [7:0] TRAP_SW_HI = 8'h89;

  typedef enum logic [7:0] {
    MODE_REG      = 8'h01, MODE_REG_DEF  = 8'h02, MODE_AINC = 8'h04, MODE_AINC_DEF = 8'h08,
    MODE_ADEC     = 8'h10, MODE_ADEC_DEF = 8'h20, MODE_IDX  = 8'h40, MODE_IDX_DEF  = 8'h80
  } mfd_mode_type;

  typedef enum logic [7:0] {
    CLS_NONE = 8'h01, CLS_SINGLE = 8'h02, CLS_DOUBLE = 8'h04, CLS_REGDST = 8'h08,
    CLS_BRANCH = 8'h10, CLS_CALL = 8'h20, CLS_RETURN = 8'h40, CLS_TRAP = 8'h80
  } mfd_class_type;

  typedef enum logic [4:0] {
    OP_NONE, OP_CLR, OP_COM, OP_INC, OP_DEC, OP_NEG, OP_TST, OP_ASR, OP_ASL, OP_ROR, OP_ROL,
    OP_BYTE_SWAP, OP_ADC, OP_SBC, OP_SIGN_EXT, OP_NOP, OP_MARK_LOW, OP_LOCKUPD, OP_COPY, OP_ADD, OP_SUB,
    OP_CMP, OP_BIT, OP_BIC, OP_BIS, OP_XOR, OP_SHIFT_ARITH, OP_SHIFT_ARITH_COMB, OP_PRODUCT, OP_DIV,
    OP_EMU_TRAP, OP_TRAP
  } mfd_op_type;

  typedef enum logic [4:0] {
    BR_NONE, BR_ALWAYS, BR_NE, BR_EQ, BR_GE, BR_LT, BR_GT, BR_LE, BR_PL, BR_MI,
    BR_HI, BR_LOS, BR_VC, BR_VS, BR_CC, BR_CS, BR_DEC_LOOP
  } mfd_branch_type;

  typedef struct packed {
    mfd_mode_type mode;
    logic [2:0]   reg_num;
  } mfd_spec_type;

  typedef struct packed {
    mfd_class_type  cls;
    mfd_op_type     op;
    mfd_branch_type br_cond;
    logic           byte_op;
    mfd_spec_type   src;
    mfd_spec_type   dst;
    logic           src_is_reg;
    logic [2:0]     link_reg;
    logic [15:0]    br_target;
    logic [7:0]     trap_code;
  } mfd_dec_type;
endpackage : mfd_pkg
`default_nettype wire

// File: test/mfd_properties.sv
// checker: decode properties watched at the decoder ports
// assumes one clock domain; bound onto every decoder instance
`default_nettype none
module mfd_properties
  import mfd_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              fetch_valid,
  input wire logic [WORD_W-1:0] fetch_word,
  input wire logic [WORD_W-1:0] fetch_pc_next,
  input wire logic              dec_valid,
  input wire logic              dec_illegal,
  input wire mfd_dec_type       dec_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w_reg;
  logic [15:0] bt_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // word and branch target of the fetch just taken, so consequents see the cause
  always_ff @(posedge core_clk) begin
    w_reg  <= fetch_word;
    bt_reg <= fetch_pc_next + {{7{fetch_word[7]}}, fetch_word[7:0], 1'b0};
  end
////////////////////////////////////////
  property p_answer; fetch_valid |=> dec_valid && (dec_illegal == (dec_out.cls == CLS_NONE)); endproperty
  property p_quiet; !fetch_valid |=> !dec_valid && $stable(dec_out) && $stable(dec_illegal); endproperty
  property p_single; fetch_valid && fetch_word[14:6] == SO_CLR |=> dec_out.op == OP_CLR
    && dec_out.byte_op == w_reg[15] && dec_out.dst.reg_num == w_reg[2:0]; endproperty
  property p_copy; fetch_valid && fetch_word[14:12] == DO_COPY |=> dec_out.op == OP_COPY && dec_out.byte_op == w_reg[15]
    && dec_out.src.reg_num == w_reg[8:6] && dec_out.dst.reg_num == w_reg[2:0]; endproperty
  property p_mode; fetch_valid && fetch_word[14:12] == DO_COPY |=> dec_out.src.mode == (8'h01 << w_reg[11:9])
    && dec_out.dst.mode == (8'h01 << w_reg[5:3]); endproperty
  property p_addsub; fetch_valid && fetch_word[14:12] == DO_ADDSUB |=> !dec_out.byte_op
    && dec_out.op == (w_reg[15] ? OP_SUB : OP_ADD); endproperty
  property p_branch; fetch_valid && fetch_word[15:8] == 8'h01 ##1 dec_valid |-> dec_out.cls == CLS_BRANCH
    && dec_out.br_target == bt_reg; endproperty
  property p_call; fetch_valid && fetch_word[15:9] == 7'h04 |=> dec_out.cls == CLS_CALL
    && dec_out.link_reg == w_reg[8:6] && dec_out.dst.reg_num == w_reg[2:0]; endproperty
  property p_ret; fetch_valid && fetch_word[15:3] == 13'h0010 |=> dec_out.cls == CLS_RETURN
    && dec_out.link_reg == w_reg[2:0]; endproperty
  property p_trap; fetch_valid && fetch_word[15:8] == TRAP_SW_HI |=> dec_out.op == OP_TRAP
    && dec_out.trap_code == w_reg[7:0]; endproperty
  a_answer: assert property (p_answer) else $error("no decode one cycle after fetch");
  a_quiet: assert property (p_quiet) else $error("decode changed without fetch");
  a_single: assert property (p_single) else $error("single operand fields wrong");
  a_copy: assert property (p_copy) else $error("copy fields wrong");
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  a_addsub: assert property (p_addsub) else $error("add or subtract wrong");
  a_branch: assert property (p_branch) else $error("branch target wrong");
  a_call: assert property (p_call) else $error("call fields wrong");
  a_ret: assert property (p_ret) else $error("return fields wrong");
  a_trap: assert property (p_trap) else $error("trap code wrong");
  c_call: cover property (p_call);
  c_branch: cover property (fetch_valid && fetch_word[15:8] == 8'h01);
  c_pair: cover property (fetch_valid ##1 fetch_valid);
endmodule : mfd_properties
bind mfd_decoder mfd_properties i_props (.core_clk(core_clk), .rstn(rstn), .fetch_valid(fetch_valid),
  .fetch_word(fetch_word), .fetch_pc_next(fetch_pc_next), .dec_valid(dec_valid), .dec_illegal(dec_illegal),
  .dec_out(dec_out));
`default_nettype wire

// File: test/mfd_prog_mem.sv
// program memory model: hands out one loaded word per run cycle with the pc after it
// assumes the bench loads words before running them
`default_nettype none
module mfd_prog_mem
  import mfd_pkg::*;
#(
  parameter logic [15:0] BASE = 16'h0100
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              load_en,
  input  wire logic [7:0]        load_addr,
  input  wire logic [15:0]       load_data,
  input  wire logic              run,
  output var  logic              fetch_valid = 1'b0,
  output var  logic [WORD_W-1:0] fetch_word = 16'h0000,
  output var  logic [WORD_W-1:0] fetch_pc_next = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [15:0] pc_reg = BASE;
  always_ff @(posedge core_clk) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
    fetch_valid <= rstn && run;
    if (rstn && run) begin
      fetch_word    <= mem[pc_reg[8:1]];
      fetch_pc_next <= pc_reg + 16'h0002;
      pc_reg        <= pc_reg + 16'h0002;
    end else begin
      // idle bus toggles so a stale word is never mistaken for a fresh one
      fetch_word    <= ~fetch_word;
      fetch_pc_next <= ~fetch_pc_next;
    end
  end
endmodule : mfd_prog_mem
`default_nettype wire

// File: test/testbench.sv
// testbench: decoder fed by the program memory model, every decode judged
// assumes the checker binds itself onto the decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mfd_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, load_en = 1'b0, run = 1'b0, fetch_valid, dec_valid, dec_illegal;
  logic [7:0]  load_addr = 8'h00;
  logic [15:0] load_data = 16'h0000, fetch_word, fetch_pc_next, pc = 16'h0100, pcn;
  mfd_dec_type dec_out;
  int failures = 0, num_checks = 0, cycles = 0;
  mfd_prog_mem i_mem (.core_clk(core_clk), .rstn(rstn), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .run(run), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_pc_next(fetch_pc_next));
  mfd_decoder i_dut (.core_clk(core_clk), .rstn(rstn), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_pc_next(fetch_pc_next), .dec_valid(dec_valid), .dec_illegal(dec_illegal), .dec_out(dec_out));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // load one word, run it once, settle just after the decode edge
  task automatic dec(input logic [15:0] w);
    pcn = pc + 16'h0002;
    @(posedge core_clk);
    load_en   <= 1'b1;
    load_addr <= pc[8:1];
    load_data <= w;
    @(posedge core_clk);
    load_en <= 1'b0;
    run     <= 1'b1;
    @(posedge core_clk);
    run <= 1'b0;
    @(posedge core_clk);
    #1 chk(dec_valid, 1'b1);
    pc = pcn;
  endtask : dec
////////////////////////////////////////
  task automatic t_double();
    mfd_op_type ops[5] = '{OP_COPY, OP_CMP, OP_BIT, OP_BIC, OP_BIS};
    logic [2:0] k;
    for (int i = 0; i < 10; i++) begin
      k = 3'(i % 5 + 1);
      dec({i[0], k, k, 3'h2, ~k, 3'h5});
      chk(dec_out.cls, CLS_DOUBLE);
      chk(dec_out.op, ops[k - 3'h1]);
      chk(dec_out.byte_op, i[0]);
      chk(dec_out.src.mode, 8'h01 << k);
      chk(dec_out.dst.mode, 8'h01 << ~k);
      chk({dec_out.src.reg_num, dec_out.dst.reg_num}, 6'h15);
    end
    for (int b = 0; b < 2; b++) begin
      dec({b[0], 3'h6, 6'h01, 6'h3C});
      chk(dec_out.op, b[0] ? OP_SUB : OP_ADD);
      chk(dec_out.byte_op, 1'b0);
      chk({dec_out.src.mode, dec_out.dst.mode}, {MODE_REG, MODE_IDX_DEF});
    end
  endtask : t_double
  task automatic t_regdst();
    mfd_op_type ops[5] = '{OP_PRODUCT, OP_DIV, OP_SHIFT_ARITH, OP_SHIFT_ARITH_COMB, OP_XOR};
    for (int e = 0; e < 5; e++) begin
      dec({4'h7, e[2:0], 3'h3, 6'h17});
      chk(dec_out.op, ops[e]);
      if (e < 4) chk({dec_out.cls, dec_out.dst.reg_num, dec_out.src}, {CLS_REGDST, 3'h3, MODE_AINC, 3'h7});
      else chk({dec_out.src.reg_num, dec_out.dst}, {3'h3, MODE_AINC, 3'h7});
    end
  endtask : t_regdst
  task automatic t_single();
    logic [8:0] codes[16] = '{SO_BYTE_SWAP, SO_CLR, SO_COM, SO_INC, SO_DEC, SO_NEG, SO_ADC, SO_SBC, SO_TST, SO_ROR,
      SO_ROL, SO_ASR, SO_ASL, SO_SIGN_EXT, SO_MARK_LOW, SO_LOCKUPD};
    mfd_op_type ops[16] = '{OP_BYTE_SWAP, OP_CLR, OP_COM, OP_INC, OP_DEC, OP_NEG, OP_ADC, OP_SBC, OP_TST, OP_ROR,
      OP_ROL, OP_ASR, OP_ASL, OP_SIGN_EXT, OP_MARK_LOW, OP_LOCKUPD};
    for (int i = 0; i < 16; i++) begin
      dec({1'b0, codes[i], 6'h0B});
      chk(dec_out.op, ops[i]);
      chk({dec_out.cls, dec_out.byte_op, dec_out.dst}, {CLS_SINGLE, 1'b0, MODE_REG_DEF, 3'h3});
    end
    dec({1'b1, SO_TST, 6'h3E});
    chk({dec_out.op, dec_out.byte_op, dec_out.dst}, {OP_TST, 1'b1, MODE_IDX_DEF, 3'h6});
    dec(NOP_WORD);
    chk(dec_out.op, OP_NOP);
  endtask : t_single
  task automatic t_branch();
    logic [7:0] off;
    for (int i = 0; i < 15; i++) begin
      off = i[0] ? 8'h7F : 8'h80;
      dec({i < 7 ? 8'(i + 1) : 8'(i + 121), off});
      chk({dec_out.cls, dec_out.br_cond}, {CLS_BRANCH, 5'(i + 1)});
      chk(dec_out.br_target, 16'(pcn + {{7{off[7]}}, off, 1'b0}));
    end
    dec({7'h3F, 3'h4, 6'h05});
    chk({dec_out.br_cond, dec_out.link_reg, dec_out.br_target}, {BR_DEC_LOOP, 3'h4, pcn - 16'h000A});
  endtask : t_branch
  task automatic t_call();
    for (int r = 0; r < 8; r++) begin
      if (r != 6) begin
        dec({7'h04, r[2:0], 3'h1, ~r[2:0]});
        chk({dec_out.cls, dec_out.link_reg, dec_out.dst}, {CLS_CALL, r[2:0], MODE_REG_DEF, ~r[2:0]});
        dec({13'h0010, r[2:0]});
        chk({dec_out.cls, dec_out.link_reg}, {CLS_RETURN, r[2:0]});
      end
    end
  endtask : t_call
  task automatic t_trap();
    for (int t = 0; t < 4; t++) begin
      dec({t[0] ? TRAP_SW_HI : TRAP_EMU_HI, 8'(t * 85)});
      chk({dec_out.cls, dec_out.op, dec_out.trap_code},
          {CLS_TRAP, t[0] ? OP_TRAP : OP_EMU_TRAP, 8'(t * 85)});
      chk({dec_out.src, dec_out.dst}, {MODE_REG, 3'h0, MODE_REG, 3'h0});
    end
  endtask : t_trap
  // unknown word, then copy and branch fetched on back-to-back cycles
  task automatic t_pair();
    dec(16'h0000);
    chk({dec_illegal, dec_out.cls}, {1'b1, CLS_NONE});
    @(posedge core_clk);
    load_en   <= 1'b1;
    load_addr <= pc[8:1];
    load_data <= 16'h1001;
    @(posedge core_clk);
    load_addr <= pc[8:1] + 8'h01;
    load_data <= 16'h01FE;
    @(posedge core_clk);
    load_en <= 1'b0;
    run     <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    run <= 1'b0;
    #1 chk({dec_valid, dec_illegal, dec_out.op}, {2'h2, OP_COPY});
    @(posedge core_clk);
    #1 chk({dec_valid, dec_out.cls, dec_out.br_cond, dec_out.br_target}, {1'b1, CLS_BRANCH, BR_ALWAYS, pc});
    @(posedge core_clk);
    #1 chk({dec_valid, dec_out.cls}, {1'b0, CLS_BRANCH});
    pc = pc + 16'h0004;
  endtask : t_pair
////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    #1 chk({dec_valid, dec_illegal, dec_out.cls, dec_out.op}, {2'h0, CLS_NONE, OP_NONE});
    @(posedge core_clk);
    rstn <= 1'b1;
    t_double();
    t_regdst();
    t_single();
    t_branch();
    t_call();
    t_trap();
    t_pair();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
